// ==== srhk_defines.svh ====
// Offsets, field positions, codes and timing counts of the housekeeping registers
`ifndef SRHK_DEFINES_SVH
`define SRHK_DEFINES_SVH
`define SRHK_ADDR_COR_CFG      9'h1ae
`define SRHK_ADDR_UNLOCK       9'h1af
`define SRHK_ADDR_RST_LO       9'h1b0
`define SRHK_ADDR_RST_HI       9'h1b1
`define SRHK_ADDR_DRVSTAT      9'h1b2
`define SRHK_ADDR_LOCK         9'h1ad
`define SRHK_COR_DRV_BIT       15
`define SRHK_COR_DIAG_LSB      0
`define SRHK_COR_STAT_LSB      8
`define SRHK_COR_MASK          16'hbf3f
`define SRHK_COR_RESET         16'h0000
`define SRHK_UNLOCK_KEY        16'h1337
`define SRHK_RST_CODE_LO       16'hf473
`define SRHK_RST_CODE_HI       16'h57a1
`define SRHK_RST_CODE_RESET    16'h0000
`define SRHK_SOFT_RST_CYCLES   4'h8
`define SRHK_DRVSTAT_RESET     7'h20
`define SRHK_DRVSTAT_LIVE_BIT  4
`define SRHK_DRVSTAT_DRVEN_BIT 5
`endif

// ==== srhk_pkg.sv ====
// Types shared by the housekeeping register files
package srhk_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        backdoor;
    logic [8:0]  addr;
    logic [15:0] wdata;
  } srhk_acc_t;
  typedef enum logic [1:0] {
    SRHK_IDLE  = 2'b00,
    SRHK_PULSE = 2'b01,
    SRHK_CLEAR = 2'b11
  } srhk_rst_state_t;
endpackage

// ==== srhk_soft_reset.sv ====
// Soft reset sequencer: fixed-length pulse then code clear request
`timescale 1ns/1ps
`include "srhk_defines.svh"
module srhk_soft_reset (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Control
  input  wire logic trigger,
  output logic      serial_soft_reset,
  output logic      clear_codes
);
  srhk_pkg::srhk_rst_state_t state;
  logic [3:0]                count;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= srhk_pkg::SRHK_IDLE;
      count <= 4'h0;
    end else begin
      case (state)
        srhk_pkg::SRHK_IDLE: begin
          count <= 4'h0;
          if (trigger) begin
            state <= srhk_pkg::SRHK_PULSE;
          end
        end
        srhk_pkg::SRHK_PULSE: begin
          count <= count + 4'h1;
          if (count == `SRHK_SOFT_RST_CYCLES - 4'h1) begin
            state <= srhk_pkg::SRHK_CLEAR;
          end
        end
        default: begin
          state <= srhk_pkg::SRHK_IDLE;
        end
      endcase
    end
  end

  assign serial_soft_reset = (state == srhk_pkg::SRHK_PULSE);
  assign clear_codes       = (state == srhk_pkg::SRHK_CLEAR);

  a_pulse_length: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(serial_soft_reset) |-> serial_soft_reset [*8] ##1 (!serial_soft_reset && clear_codes))
    else $error("soft reset pulse not eight cycles");
endmodule

// ==== srhk_regs.sv ====
// Housekeeping register bank: clear-on-read enables, unlock, soft reset code, driver status
//
// Summary of operation
// - Only external SPI reads clear registers; microcore backdoor reads never do.
// - Bit 15 set makes an SPI read of driver status clear latched bits.
// - Bits 0-5 enable diagnostics clear-on-read per core/channel pair, in order.
// - All three diagnostics registers of a pair clear together, on reading the third.
// - Bits 8-13 enable microcore status clear-on-read per core/channel pair.
// - A set arriving with a read clear wins and shows on the next read.
// - Writing 1337h to the unlock register clears the device lock.
// - Codes F473h and 57A1h in the two slices trigger the soft reset.
// - Soft reset lasts eight cycles, then both code slices clear to zero.
// - Seven-bit driver status latches error conditions 0-3 and 6 and a drven drop in bit 5; bit 4 is live.
// - Two 16-bit code slices form one 32-bit register, resetting to zero.
// - Driver error bit clears on write only when condition gone; read needs enable.
// - Correct unlock password also clears the three data RAM private-area locks.
`timescale 1ns/1ps
`include "srhk_defines.svh"
module srhk_regs #(
  parameter int DIAG_BASE = 9'h100,
  parameter int STAT_BASE = 9'h120
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Register access from the SPI slave and the microcore backdoor
  input  wire srhk_pkg::srhk_acc_t acc,
  output logic [15:0]           rdata,
  // Driver status sources, condition levels already qualified by their enables
  input  wire logic [6:0]       drv_err_cond,
  input  wire logic             drven_pin,
  // Device lock register, owned elsewhere
  output logic                  lock_clear,
  // Clear strobes toward diagnostics and microcore status registers
  output logic [5:0]            diag_clear,
  output logic [5:0]            stat_clear,
  // Global soft reset
  output logic                  serial_soft_reset
);
  logic [15:0] cor_cfg;
  logic [15:0] code_lo;
  logic [15:0] code_hi;
  logic [6:0]  drv_stat;
  logic        drven_s1;
  logic        drven_s2;
  logic        clear_codes;
  logic        trigger;
  logic        rd_ext;
  logic [6:0]  drv_set;

  function automatic logic hit(input logic [8:0] a, input logic [8:0] b);
    return a == b;
  endfunction

  // External reads only; backdoor reads are side-effect free
  assign rd_ext = acc.rd && !acc.backdoor;

  // Clear-on-read configuration
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cor_cfg <= `SRHK_COR_RESET;
    end else if (acc.wr && hit(acc.addr, `SRHK_ADDR_COR_CFG)) begin
      cor_cfg <= acc.wdata & `SRHK_COR_MASK;
    end
  end

  // Code slices; the code clear after the pulse beats a simultaneous write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      code_lo <= `SRHK_RST_CODE_RESET;
      code_hi <= `SRHK_RST_CODE_RESET;
    end else if (clear_codes) begin
      code_lo <= `SRHK_RST_CODE_RESET;
      code_hi <= `SRHK_RST_CODE_RESET;
    end else if (acc.wr && hit(acc.addr, `SRHK_ADDR_RST_LO)) begin
      code_lo <= acc.wdata;
    end else if (acc.wr && hit(acc.addr, `SRHK_ADDR_RST_HI)) begin
      code_hi <= acc.wdata;
    end
  end

  // Both slices must match; one-shot because codes clear after the pulse
  assign trigger = (code_lo == `SRHK_RST_CODE_LO) && (code_hi == `SRHK_RST_CODE_HI);

  srhk_soft_reset u_soft_reset (
    .sys_clk           (sys_clk),
    .reset_n           (reset_n),
    .trigger           (trigger),
    .serial_soft_reset (serial_soft_reset),
    .clear_codes       (clear_codes)
  );

  // Unlock also releases the three data RAM private-area locks held by the lock register
  assign lock_clear = acc.wr && hit(acc.addr, `SRHK_ADDR_UNLOCK) && (acc.wdata == `SRHK_UNLOCK_KEY);

  // Clear strobes for registers outside; their owners give set priority over clear
  always_comb begin
    diag_clear = '0;
    stat_clear = '0;
    for (int i = 0; i < 6; i++) begin
      // Third register of each diagnostics triple sits at base + 3*i + 2
      if (rd_ext && cor_cfg[`SRHK_COR_DIAG_LSB + i]
          && acc.addr == 9'(DIAG_BASE + 3 * i + 2)) begin
        diag_clear[i] = 1'b1;
      end
      if (rd_ext && cor_cfg[`SRHK_COR_STAT_LSB + i] && acc.addr == 9'(STAT_BASE + i)) begin
        stat_clear[i] = 1'b1;
      end
    end
  end

  // Driver enable pin is asynchronous; reset to its idle high level so reset release shows no false drop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      drven_s1 <= 1'b1;
      drven_s2 <= 1'b1;
    end else begin
      drven_s1 <= drven_pin;
      drven_s2 <= drven_s1;
    end
  end

  // Drven latch bit is active low and reset to 1; bit 4 is a live copy that never latches, others latch high
  always_comb begin
    drv_set = drv_err_cond;
    drv_set[`SRHK_DRVSTAT_DRVEN_BIT] = !drven_s2;
    drv_set[`SRHK_DRVSTAT_LIVE_BIT]  = 1'b0;
  end

  // Driver status latch; a pending condition always wins over a clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      drv_stat <= `SRHK_DRVSTAT_RESET;
    end else begin
      for (int b = 0; b < 7; b++) begin
        if (b == `SRHK_DRVSTAT_LIVE_BIT) begin
          drv_stat[b] <= drven_s2;
        end else if (b == `SRHK_DRVSTAT_DRVEN_BIT) begin
          if (drv_set[b]) begin
            drv_stat[b] <= 1'b0;
          end else if (hit(acc.addr, `SRHK_ADDR_DRVSTAT)
                       && (acc.wr || (rd_ext && cor_cfg[`SRHK_COR_DRV_BIT]))) begin
            drv_stat[b] <= 1'b1;
          end
        end else if (drv_set[b]) begin
          drv_stat[b] <= 1'b1;
        end else if (hit(acc.addr, `SRHK_ADDR_DRVSTAT)
                     && (acc.wr || (rd_ext && cor_cfg[`SRHK_COR_DRV_BIT]))) begin
          drv_stat[b] <= 1'b0;
        end
      end
    end
  end

  // Read data registered; write-only registers read zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else if (acc.rd) begin
      if (hit(acc.addr, `SRHK_ADDR_COR_CFG)) begin
        rdata <= cor_cfg;
      end else if (hit(acc.addr, `SRHK_ADDR_DRVSTAT)) begin
        rdata <= {9'h000, drv_stat};
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  a_backdoor_noclr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (acc.rd && acc.backdoor) |-> (diag_clear == 6'h00 && stat_clear == 6'h00))
    else $error("backdoor read produced a clear");

  a_drv_read_clr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rd_ext && !acc.wr && hit(acc.addr, `SRHK_ADDR_DRVSTAT) && cor_cfg[`SRHK_COR_DRV_BIT]
     && drv_set[0] == 1'b0) |=> drv_stat[0] == 1'b0)
    else $error("driver status not cleared on read");

  a_drv_noclr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rd_ext && !acc.wr && !cor_cfg[`SRHK_COR_DRV_BIT] && drv_stat[0]) |=> drv_stat[0])
    else $error("driver status cleared without enable");

  a_set_wins: assert property (@(posedge sys_clk) disable iff (!reset_n)
    drv_set[1] |=> drv_stat[1])
    else $error("driver error set lost");

  a_diag_third: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rd_ext && cor_cfg[0] && acc.addr == 9'(DIAG_BASE + 2)) |-> diag_clear[0])
    else $error("diag clear missing on third register read");

  a_unlock_key: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lock_clear |-> (acc.wdata == 16'h1337 && acc.addr == 9'h1af))
    else $error("unlock without correct key");

  a_reset_trig: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(serial_soft_reset) |-> $past(code_lo) == 16'hf473 && $past(code_hi) == 16'h57a1)
    else $error("soft reset without full code");

  a_codes_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(serial_soft_reset) |=> (code_lo == 16'h0000 && code_hi == 16'h0000))
    else $error("codes not cleared after soft reset");

  a_stat_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rd_ext && cor_cfg[`SRHK_COR_STAT_LSB] && acc.addr == 9'(STAT_BASE)) |-> stat_clear[0])
    else $error("status clear missing on enabled read");

  a_unlock_hit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (acc.wr && hit(acc.addr, `SRHK_ADDR_UNLOCK) && acc.wdata == `SRHK_UNLOCK_KEY) |-> lock_clear)
    else $error("correct key did not unlock");

  a_drven_latch: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !drven_s2 |=> !drv_stat[`SRHK_DRVSTAT_DRVEN_BIT])
    else $error("driver enable drop not latched");

  a_live_copy: assert property (@(posedge sys_clk) disable iff (!reset_n)
    drven_s2 |=> drv_stat[`SRHK_DRVSTAT_LIVE_BIT])
    else $error("driver enable live copy stale");

  a_drv_wr_clr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (acc.wr && hit(acc.addr, `SRHK_ADDR_DRVSTAT) && !drv_set[1]) |=> !drv_stat[1])
    else $error("gone driver error not cleared by write");
endmodule

// ==== srhk_spi_master.sv ====
// SPI master model: issues one register access at a time toward the bank
`timescale 1ns/1ps
`include "srhk_defines.svh"
module srhk_spi_master (
  // Clock
  input  wire logic           sys_clk,
  // Access path and read data
  output srhk_pkg::srhk_acc_t acc,
  input  wire logic [15:0]    rdata
);
  initial acc = '0;
  // Strobe for one cycle, then idle with inverted address and data so stale values never look valid
  task automatic xfer(input logic w, input logic bd, input logic [8:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    @(posedge sys_clk);
    #1 acc = '{wr: w, rd: !w, backdoor: bd, addr: a, wdata: d};
    @(posedge sys_clk);
    #1 acc = '{wr: 1'b0, rd: 1'b0, backdoor: 1'b0, addr: ~a, wdata: ~d};
    q = rdata;
  endtask
  // Both code slices, low half first
  task automatic soft_reset_req(input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] q;
    xfer(1'b1, 1'b0, `SRHK_ADDR_RST_LO, lo, q);
    xfer(1'b1, 1'b0, `SRHK_ADDR_RST_HI, hi, q);
  endtask
endmodule

// ==== spi_reg_housekeeping_tb.sv ====
// Self-checking bench for the housekeeping register bank
`timescale 1ns/1ps
`include "srhk_defines.svh"
module spi_reg_housekeeping_tb;
  localparam int DB = 'h100;
  localparam int SB = 'h120;
  logic                sys_clk = 1'b0;
  logic                reset_n = 1'b0;
  logic [6:0]          drv_err_cond = '0;
  logic                drven_pin = 1'b1;
  srhk_pkg::srhk_acc_t acc;
  logic [15:0]         rdata;
  logic [15:0]         q;
  logic                lock_clear;
  logic                serial_soft_reset;
  logic [5:0]          diag_clear;
  logic [5:0]          stat_clear;
  logic [15:0]         seen_diag;
  logic [15:0]         seen_stat;
  logic [15:0]         seen_lock;
  logic [31:0]         rng = 32'd23055;
  int                  bad_count = 0;
  int                  num_checks = 0;
  int                  rst_len = 0;
  int                  m_cfg;
  int                  m_drv = 'h20;
  int                  n;
  always #5 sys_clk = ~sys_clk;
  srhk_regs #(.DIAG_BASE(DB), .STAT_BASE(SB)) u_srhk_regs (.sys_clk(sys_clk), .reset_n(reset_n), .acc(acc),
    .rdata(rdata), .drv_err_cond(drv_err_cond), .drven_pin(drven_pin), .lock_clear(lock_clear),
    .diag_clear(diag_clear), .stat_clear(stat_clear), .serial_soft_reset(serial_soft_reset));
  srhk_spi_master u_srhk_spi_master (.sys_clk(sys_clk), .acc(acc), .rdata(rdata));
  // Clear strobes last one cycle, so they are caught mid-cycle of the access
  always @(negedge sys_clk) begin
    if (acc.rd || acc.wr) begin
      seen_diag = {10'h000, diag_clear};
      seen_stat = {10'h000, stat_clear};
      seen_lock = {15'h0000, lock_clear};
    end
    if (serial_soft_reset === 1'b1) rst_len++;
  end
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input int a, input int d);
    u_srhk_spi_master.xfer(1'b1, 1'b0, 9'(a), 16'(d), q);
  endtask
  task automatic rd(input int a, input logic bd = 1'b0);
    u_srhk_spi_master.xfer(1'b0, bd, 9'(a), 16'h0000, q);
  endtask
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    rd(`SRHK_ADDR_COR_CFG);
    check("cor_cfg reset", q, 16'h0000);
    rd(DB + 2);
    check("diag clear while disabled", seen_diag, 16'h0000);
    m_cfg = xs() & 'hbf3f;
    wr(`SRHK_ADDR_COR_CFG, m_cfg | 'h4000);
    rd(`SRHK_ADDR_COR_CFG);
    check("cor_cfg readback", q, 16'(m_cfg));
    $display("test reset_and_config done");
    for (int i = 0; i < 6; i++) begin
      wr(`SRHK_ADDR_COR_CFG, (1 << i) | (1 << (8 + i)));
      rd(DB + 3 * i);
      check("diag first of triple", seen_diag, 16'h0000);
      rd(DB + 3 * i + 2, 1'b1);
      check("diag backdoor read", seen_diag, 16'h0000);
      rd(DB + 3 * i + 2);
      check("diag third of triple", seen_diag, 16'(1 << i));
      rd(DB + 3 * ((i + 1) % 6) + 2);
      check("diag other pair", seen_diag, 16'h0000);
      rd(SB + i);
      check("status clear", seen_stat, 16'(1 << i));
      rd(SB + (i + 1) % 6);
      check("status other pair", seen_stat, 16'h0000);
    end
    $display("test clear_on_read done");
    rd(`SRHK_ADDR_DRVSTAT);
    check("drvstat reset", q, 16'(m_drv | 'h10));
    drv_err_cond = 7'h4f;
    repeat (2) @(posedge sys_clk);
    #1 drv_err_cond = 7'h01;
    m_drv = m_drv | 'h4f;
    rd(`SRHK_ADDR_DRVSTAT);
    rd(`SRHK_ADDR_DRVSTAT);
    check("drvstat latched", q, 16'(m_drv | 'h10));
    wr(`SRHK_ADDR_DRVSTAT, 0);
    m_drv = 'h21;
    rd(`SRHK_ADDR_DRVSTAT);
    check("drvstat write clear", q, 16'(m_drv | 'h10));
    wr(`SRHK_ADDR_COR_CFG, 'h8000);
    rd(`SRHK_ADDR_DRVSTAT);
    rd(`SRHK_ADDR_DRVSTAT, 1'b1);
    check("drvstat set wins", q, 16'(m_drv | 'h10));
    drv_err_cond = 7'h00;
    rd(`SRHK_ADDR_DRVSTAT, 1'b1);
    rd(`SRHK_ADDR_DRVSTAT);
    check("drvstat before clear", q, 16'(m_drv | 'h10));
    m_drv = 'h20;
    rd(`SRHK_ADDR_DRVSTAT);
    check("drvstat read clear", q, 16'(m_drv | 'h10));
    drven_pin = 1'b0;
    repeat (4) @(posedge sys_clk);
    m_drv = 'h00;
    rd(`SRHK_ADDR_DRVSTAT);
    check("drven low latched", q, 16'(m_drv));
    drven_pin = 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(`SRHK_ADDR_DRVSTAT);
    check("drven latch holds", q, 16'(m_drv | 'h10));
    m_drv = 'h20;
    rd(`SRHK_ADDR_DRVSTAT);
    check("drven latch read clear", q, 16'(m_drv | 'h10));
    $display("test driver_status done");
    wr(`SRHK_ADDR_UNLOCK, 'h1337);
    check("unlock key", seen_lock, 16'h0001);
    wr(`SRHK_ADDR_UNLOCK, 'h1337 ^ ((xs() & 'hffff) | 1));
    check("wrong key", seen_lock, 16'h0000);
    $display("test unlock done");
    rst_len = 0;
    // Order keeps the two slices from ever matching together
    u_srhk_spi_master.soft_reset_req(16'hf473, 16'h57a0);
    u_srhk_spi_master.soft_reset_req(16'hf472, 16'h57a1);
    repeat (12) @(posedge sys_clk);
    check("no reset on wrong code", 16'(rst_len), 16'h0000);
    wr(`SRHK_ADDR_RST_LO, 'hf473);
    for (n = 0; n < 30 && !(rst_len == 8 && serial_soft_reset === 1'b0); n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n == 30) begin
      bad_count++;
      $display("ERROR soft reset wait expected pulse end seen timeout");
      conclude();
    end
    check("soft reset length", 16'(rst_len), 16'h0008);
    wr(`SRHK_ADDR_RST_HI, 'h57a1);
    repeat (12) @(posedge sys_clk);
    check("codes cleared", 16'(rst_len), 16'h0008);
    $display("test soft_reset done");
    conclude();
  end
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
endmodule
